// file: logic/stm_rx_monitor.sv
// Receiver-side lane test and error monitor with its register file.
`timescale 1ns/1ps
module stm_rx_monitor
  import stm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  stm_link_if.dev link
);
  import stm_pkg::*;

  logic [7:0] lane_inv_reg, eq_lo_reg, eq_hi_reg, loop_mask_reg, loop_ctrl_reg;
  logic [7:0] pat_en_reg, pat_ctrl_reg, tpl_ctrl_reg, ref_lo_reg, ref_hi_reg;
  logic [7:0] qual_reg, ilas_mode_reg;
  logic [23:0] limit_reg;
  logic tpl_iq_reg, tpl_fail_reg, run_prev_reg, running_reg, half_phase_reg;
  logic [7:0] err_ctrl_reg [LANES];
  logic [7:0] err_hold_reg [LANES];
  logic [7:0] err_cnt_reg [LANES][3];
  logic [LANES-1:0] nit_pend_reg, locked_reg, aligned_reg, pass_reg;
  logic [2:0] kcnt_reg [LANES];
  logic [30:0] hist_reg [LANES];
  logic [4:0] seed_reg [LANES];
  logic [TALLY_W-1:0] tally_reg [LANES];
  logic [30:0] gen_reg;

  wire [1:0] poly_sel = pat_ctrl_reg[3:2];
  wire [2:0] tally_sel = pat_ctrl_reg[6:4];
  wire pat_clear = pat_ctrl_reg[B_PAT_CLEAR];
  wire pat_run = pat_ctrl_reg[B_PAT_RUN];
  wire err_ctrl_hit = reg_wr && reg_addr[11:3] == A_ERR_CTRL0[11:3];
  wire err_hold_hit = reg_wr && reg_addr[11:3] == A_ERR_HOLD0[11:3];
  wire [2:0] wr_lane = reg_addr[2:0];
  wire [2:0] rd_lane = reg_addr[4:2];
  wire [1:0] rd_type = reg_addr[1:0];
  wire [7:0] rx_bits;
  wire [7:0] bde_event;
  wire [SAMPLE_W-1:0] fifo_out;
  wire fifo_valid;
  wire tpl_ready = tpl_ctrl_reg[B_TPL_EN];
  wire [15:0] expected = {ref_hi_reg, ref_lo_reg};
  wire tpl_pick = fifo_out[6:5] == tpl_ctrl_reg[3:2] && fifo_out[4] == tpl_iq_reg
    && fifo_out[3:0] == tpl_ctrl_reg[7:4];
  wire tpl_miss = tpl_ready && fifo_valid && tpl_pick && fifo_out[22:7] != expected;

  stm_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_sample_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(link.sample_valid),
    .in_ready(link.sample_ready),
    .in_data({link.sample_data, link.sample_conv, link.sample_iq, link.sample_index}),
    .out_valid(fifo_valid),
    .out_ready(tpl_ready),
    .out_data(fifo_out)
  );

  // Looped lanes take the internal generator instead of the pins.
  assign rx_bits = ((loop_mask_reg & {8{gen_reg[0]}}) | (~loop_mask_reg & link.lane_bit))
    ^ lane_inv_reg;
  // A disparity beside an invalid code is dropped; with the qualifier a run of invalid
  // codes yields one disparity on the next clean character.
  assign bde_event = (link.err_disp & ~link.err_nit)
    | ({8{qual_reg[B_READ_QUAL]}} & nit_pend_reg & ~link.err_nit);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lane_inv_reg <= 8'h00;
      eq_lo_reg <= 8'h00;
      eq_hi_reg <= 8'h00;
      loop_mask_reg <= 8'h00;
      loop_ctrl_reg <= 8'h00;
      pat_en_reg <= 8'h00;
      pat_ctrl_reg <= 8'h00;
      limit_reg <= 24'h000000;
      tpl_ctrl_reg <= 8'h00;
      ref_lo_reg <= 8'h00;
      ref_hi_reg <= 8'h00;
      tpl_iq_reg <= 1'b0;
      qual_reg <= 8'h00;
      ilas_mode_reg <= 8'h00;
      for (int n = 0; n < LANES; n++) begin
        err_ctrl_reg[n] <= ERR_CTRL_RESET;
        err_hold_reg[n] <= 8'h00;
      end
    end else if (reg_wr) begin
      unique case (reg_addr)
        A_LANE_INVERT: lane_inv_reg <= reg_wdata;
        A_EQ_BOOST_LO: eq_lo_reg <= reg_wdata;
        A_EQ_BOOST_HI: eq_hi_reg <= reg_wdata;
        A_LOOP_MASK: loop_mask_reg <= reg_wdata;
        A_LOOP_CTRL: loop_ctrl_reg <= {6'h00, reg_wdata[1:0]};
        A_PAT_LANE_EN: pat_en_reg <= reg_wdata;
        A_PAT_CTRL: pat_ctrl_reg <= {1'b0, reg_wdata[6:0]};
        A_PAT_LIMIT0: limit_reg[7:0] <= reg_wdata;
        A_PAT_LIMIT1: limit_reg[15:8] <= reg_wdata;
        A_PAT_LIMIT2: limit_reg[23:16] <= reg_wdata;
        A_TPL_CTRL: tpl_ctrl_reg <= {reg_wdata[7:2], reg_wdata[1:0]};
        A_TPL_REF_LO: ref_lo_reg <= reg_wdata;
        A_TPL_REF_HI: ref_hi_reg <= reg_wdata;
        A_TPL_RESULT: tpl_iq_reg <= reg_wdata[B_TPL_IQ];
        A_READ_QUAL: qual_reg <= reg_wdata;
        A_ILAS_MODE: ilas_mode_reg <= reg_wdata;
        default: begin
          if (err_ctrl_hit) begin
            err_ctrl_reg[wr_lane] <= {2'h0, reg_wdata[5:0]};
          end
          if (err_hold_hit) begin
            err_hold_reg[wr_lane] <= {5'h00, reg_wdata[2:0]};
          end
        end
      endcase
    end
  end

  // Pattern checkers, run control and the loopback generator.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_prev_reg <= 1'b0;
      running_reg <= 1'b0;
      half_phase_reg <= 1'b0;
      gen_reg <= PRBS_SEED;
      pass_reg <= 8'h00;
      for (int n = 0; n < LANES; n++) begin
        hist_reg[n] <= 31'h0;
        seed_reg[n] <= 5'h0;
        tally_reg[n] <= '0;
      end
    end else begin
      run_prev_reg <= pat_run;
      running_reg <= pat_run && (running_reg || !run_prev_reg);
      half_phase_reg <= !half_phase_reg;
      if (loop_ctrl_reg[B_LOOP_SYNC_INIT]) begin
        gen_reg <= PRBS_SEED;
      end else if (!loop_ctrl_reg[B_LOOP_HALF] || half_phase_reg) begin
        gen_reg <= {gen_reg[29:0], stm_prbs_bit(gen_reg, poly_sel)};
      end
      for (int n = 0; n < LANES; n++) begin
        pass_reg[n] <= tally_reg[n] <= limit_reg;
        if (pat_clear) begin
          seed_reg[n] <= 5'h0;
          tally_reg[n] <= '0;
        end else if (pat_en_reg[n]) begin
          hist_reg[n] <= {hist_reg[n][29:0], rx_bits[n]};
          if (seed_reg[n] < stm_prbs_order(poly_sel)) begin
            seed_reg[n] <= seed_reg[n] + 5'h1;
          end else if (running_reg && rx_bits[n] != stm_prbs_bit(hist_reg[n], poly_sel)
              && tally_reg[n] != '1) begin
            tally_reg[n] <= tally_reg[n] + 1'b1;
          end
        end
      end
    end
  end

  // Character error counters, code group lock and the sync request.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nit_pend_reg <= 8'h00;
      locked_reg <= 8'h00;
      aligned_reg <= 8'h00;
      link.sync_request_out <= 1'b1;
      for (int n = 0; n < LANES; n++) begin
        kcnt_reg[n] <= 3'h0;
        for (int t = 0; t < 3; t++) begin
          err_cnt_reg[n][t] <= 8'h00;
        end
      end
    end else begin
      link.sync_request_out <= !(&locked_reg);
      for (int n = 0; n < LANES; n++) begin
        if (link.err_nit[n]) begin
          nit_pend_reg[n] <= qual_reg[B_READ_QUAL];
        end else if (bde_event[n]) begin
          nit_pend_reg[n] <= 1'b0;
        end
        if (link.lane_k[n] && kcnt_reg[n] != CGS_K_NEEDED) begin
          kcnt_reg[n] <= kcnt_reg[n] + 3'h1;
        end else if (!link.lane_k[n] && link.sync_request_out) begin
          kcnt_reg[n] <= 3'h0;
        end
        locked_reg[n] <= kcnt_reg[n] == CGS_K_NEEDED;
        if (!locked_reg[n]) begin
          aligned_reg[n] <= 1'b0;
        end else if (link.lane_ilas[n]) begin
          // Outside ILAS test mode the aligned flag toggles on each alignment character.
          aligned_reg[n] <= ilas_mode_reg[B_ILAS_MODE] || !aligned_reg[n];
        end
        for (int t = 0; t < 3; t++) begin
          if (err_ctrl_reg[n][t]) begin
            err_cnt_reg[n][t] <= 8'h00;
          end else if (err_ctrl_reg[n][t+3] && (t == ERR_UEK ? link.err_uek[n] :
              t == ERR_NIT ? link.err_nit[n] : bde_event[n])) begin
            if (!(err_hold_reg[n][t] && err_cnt_reg[n][t] == ERR_TERMINAL)) begin
              err_cnt_reg[n][t] <= err_cnt_reg[n][t] + 8'h01;
            end
          end
        end
      end
    end
  end

  // Sample check result; a mismatch in the clearing cycle still sets the flag.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tpl_fail_reg <= 1'b0;
    end else if (tpl_miss) begin
      tpl_fail_reg <= 1'b1;
    end else if (tpl_ctrl_reg[B_TPL_CLEAR]) begin
      tpl_fail_reg <= 1'b0;
    end
  end

  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      A_LANE_INVERT: rd_mux = lane_inv_reg;
      A_EQ_BOOST_LO: rd_mux = eq_lo_reg;
      A_EQ_BOOST_HI: rd_mux = eq_hi_reg;
      A_LOOP_MASK: rd_mux = loop_mask_reg;
      A_LOOP_CTRL: rd_mux = loop_ctrl_reg;
      A_PAT_LANE_EN: rd_mux = pat_en_reg;
      A_PAT_CTRL: rd_mux = pat_ctrl_reg;
      A_PAT_LIMIT0: rd_mux = limit_reg[7:0];
      A_PAT_LIMIT1: rd_mux = limit_reg[15:8];
      A_PAT_LIMIT2: rd_mux = limit_reg[23:16];
      A_PAT_TALLY0: rd_mux = tally_reg[tally_sel][7:0];
      A_PAT_TALLY1: rd_mux = tally_reg[tally_sel][15:8];
      A_PAT_TALLY2: rd_mux = tally_reg[tally_sel][23:16];
      A_PAT_LANE_OK: rd_mux = pass_reg;
      A_TPL_CTRL: rd_mux = tpl_ctrl_reg;
      A_TPL_REF_LO: rd_mux = ref_lo_reg;
      A_TPL_REF_HI: rd_mux = ref_hi_reg;
      A_TPL_RESULT: rd_mux = {1'b0, tpl_iq_reg, 5'h00, tpl_fail_reg};
      A_CG_LOCKED: rd_mux = locked_reg;
      A_LANE_ALIGNED: rd_mux = aligned_reg;
      A_READ_QUAL: rd_mux = qual_reg;
      A_ILAS_MODE: rd_mux = ilas_mode_reg;
      default: begin
        if (reg_addr[11:3] == A_ERR_CTRL0[11:3]) begin
          rd_mux = err_ctrl_reg[reg_addr[2:0]];
        end else if (reg_addr[11:3] == A_ERR_HOLD0[11:3]) begin
          rd_mux = err_hold_reg[reg_addr[2:0]];
        end else if (reg_addr[11:5] == A_ERR_COUNT0[11:5] && rd_type != 2'h3) begin
          rd_mux = err_cnt_reg[rd_lane][rd_type];
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rd_mux;
    end
  end
endmodule // stm_rx_monitor

// file: logic/stm_pkg.sv
// Shared constants, types and the pattern function for the lane test monitor.
package stm_pkg;
  localparam int LANES = 8;
  localparam int TALLY_W = 24;
  localparam int FIFO_DEPTH = 4;
  localparam int SAMPLE_W = 23;
  localparam logic [11:0] A_LANE_INVERT = 12'h234;
  localparam logic [11:0] A_EQ_BOOST_LO = 12'h240;
  localparam logic [11:0] A_EQ_BOOST_HI = 12'h241;
  localparam logic [11:0] A_LOOP_MASK = 12'h250;
  localparam logic [11:0] A_LOOP_CTRL = 12'h251;
  localparam logic [11:0] A_PAT_LANE_EN = 12'h315;
  localparam logic [11:0] A_PAT_CTRL = 12'h316;
  localparam logic [11:0] A_PAT_LIMIT0 = 12'h317;
  localparam logic [11:0] A_PAT_LIMIT1 = 12'h318;
  localparam logic [11:0] A_PAT_LIMIT2 = 12'h319;
  localparam logic [11:0] A_PAT_TALLY0 = 12'h31a;
  localparam logic [11:0] A_PAT_TALLY1 = 12'h31b;
  localparam logic [11:0] A_PAT_TALLY2 = 12'h31c;
  localparam logic [11:0] A_PAT_LANE_OK = 12'h31d;
  localparam logic [11:0] A_TPL_CTRL = 12'h32c;
  localparam logic [11:0] A_TPL_REF_LO = 12'h32d;
  localparam logic [11:0] A_TPL_REF_HI = 12'h32e;
  localparam logic [11:0] A_TPL_RESULT = 12'h32f;
  localparam logic [11:0] A_CG_LOCKED = 12'h470;
  localparam logic [11:0] A_LANE_ALIGNED = 12'h473;
  localparam logic [11:0] A_READ_QUAL = 12'h476;
  localparam logic [11:0] A_ILAS_MODE = 12'h477;
  localparam logic [11:0] A_ERR_CTRL0 = 12'h480;
  localparam logic [11:0] A_ERR_HOLD0 = 12'h488;
  localparam logic [11:0] A_ERR_COUNT0 = 12'h4a0;
  localparam int B_PAT_CLEAR = 0;
  localparam int B_PAT_RUN = 1;
  localparam int B_LOOP_SYNC_INIT = 0;
  localparam int B_LOOP_HALF = 1;
  localparam int B_TPL_EN = 0;
  localparam int B_TPL_CLEAR = 1;
  localparam int B_TPL_IQ = 6;
  localparam int B_READ_QUAL = 4;
  localparam int B_ILAS_MODE = 7;
  localparam int ERR_UEK = 0;
  localparam int ERR_NIT = 1;
  localparam int ERR_BDE = 2;
  localparam logic [7:0] ERR_CTRL_RESET = 8'h3f;
  localparam logic [7:0] ERR_TERMINAL = 8'hff;
  localparam logic [2:0] CGS_K_NEEDED = 3'h4;
  localparam logic [1:0] SEL_PRBS7 = 2'h0;
  localparam logic [1:0] SEL_PRBS15 = 2'h1;
  localparam logic [1:0] SEL_PRBS31 = 2'h2;
  localparam logic [30:0] PRBS_SEED = 31'h7fffffff;

  typedef enum logic [4:0] {
    STM_TX_IDLE = 5'b00001,
    STM_TX_PRBS = 5'b00010,
    STM_TX_CGS = 5'b00100,
    STM_TX_ILAS = 5'b01000,
    STM_TX_SHORT_TRANSPORT_CHECK = 5'b10000
  } stm_tx_mode_t;

  // Next pattern bit; history s[0] is the newest bit.
  function automatic logic stm_prbs_bit(input logic [30:0] s, input logic [1:0] sel);
    unique case (sel)
      SEL_PRBS7: stm_prbs_bit = s[6] ^ s[5];
      SEL_PRBS15: stm_prbs_bit = s[14] ^ s[13];
      default: stm_prbs_bit = s[30] ^ s[27];
    endcase
  endfunction

  function automatic logic [4:0] stm_prbs_order(input logic [1:0] sel);
    unique case (sel)
      SEL_PRBS7: stm_prbs_order = 5'd7;
      SEL_PRBS15: stm_prbs_order = 5'd15;
      default: stm_prbs_order = 5'd31;
    endcase
  endfunction
endpackage

// file: logic/stm_link_if.sv
// Link between the lane transmitter and the receiver test monitor.
`timescale 1ns/1ps
interface stm_link_if;
  logic [7:0] lane_bit;
  logic [7:0] lane_k;
  logic [7:0] lane_ilas;
  logic [7:0] err_nit;
  logic [7:0] err_disp;
  logic [7:0] err_uek;
  logic sync_request_out;
  logic sample_valid;
  logic sample_ready;
  logic [15:0] sample_data;
  logic [1:0] sample_conv;
  logic sample_iq;
  logic [3:0] sample_index;
  modport dev(input lane_bit, lane_k, lane_ilas, err_nit, err_disp, err_uek, sample_valid,
    sample_data, sample_conv, sample_iq, sample_index, output sync_request_out, sample_ready);
  modport tx(output lane_bit, lane_k, lane_ilas, err_nit, err_disp, err_uek, sample_valid,
    sample_data, sample_conv, sample_iq, sample_index, input sync_request_out, sample_ready);
endinterface

// file: logic/stm_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module stm_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem_reg[rp_reg];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      end
      count_reg <= count_next;
      in_ready <= count_next != (AW+1)'(DEPTH);
      out_valid <= count_next != '0;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end
endmodule // stm_fifo

// file: logic/stm_tx_source.sv
// Transmitter end: pattern, code group, alignment and sample stream source.
`timescale 1ns/1ps
module stm_tx_source
  import stm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire stm_pkg::stm_tx_mode_t mode,
  input wire logic [1:0] poly_sel,
  input wire logic [7:0] inject_nit,
  input wire logic [7:0] inject_disp,
  input wire logic [7:0] inject_uek,
  input wire logic [15:0] sample_base,
  stm_link_if.tx link
);
  import stm_pkg::*;

  logic [30:0] gen_reg;
  logic [6:0] slot_reg;
  wire link_up = !link.sync_request_out;
  wire short_transport_check_go = mode == STM_TX_SHORT_TRANSPORT_CHECK && link_up;
  wire load = !link.sample_valid || link.sample_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gen_reg <= PRBS_SEED;
      link.lane_bit <= 8'h00;
      link.lane_k <= 8'h00;
      link.lane_ilas <= 8'h00;
      link.err_nit <= 8'h00;
      link.err_disp <= 8'h00;
      link.err_uek <= 8'h00;
    end else begin
      gen_reg <= {gen_reg[29:0], stm_prbs_bit(gen_reg, poly_sel)};
      link.lane_bit <= (mode == STM_TX_PRBS) ? {8{gen_reg[0]}} : 8'h00;
      // Alignment characters follow the K stream once the receiver lets go.
      link.lane_k <= {8{mode == STM_TX_CGS || (mode == STM_TX_ILAS && !link_up)}};
      link.lane_ilas <= {8{mode == STM_TX_ILAS && link_up}};
      link.err_nit <= inject_nit;
      link.err_disp <= inject_disp;
      link.err_uek <= inject_uek;
    end
  end

  // Each slot carries a distinct value so every sample position is unique.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_reg <= 7'h00;
      link.sample_valid <= 1'b0;
      link.sample_data <= 16'h0000;
      link.sample_conv <= 2'h0;
      link.sample_iq <= 1'b0;
      link.sample_index <= 4'h0;
    end else if (load) begin
      link.sample_valid <= short_transport_check_go;
      if (short_transport_check_go) begin
        slot_reg <= slot_reg + 7'h01;
        link.sample_data <= sample_base + {9'h000, slot_reg};
        link.sample_conv <= slot_reg[6:5];
        link.sample_iq <= slot_reg[4];
        link.sample_index <= slot_reg[3:0];
      end
    end
  end
endmodule // stm_tx_source

// file: verification/stm_link_properties.sv
// Assertions on the link between the lane transmitter and the test monitor.
`timescale 1ns/1ps
module stm_link_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] lane_k,
  input wire logic [7:0] lane_ilas,
  input wire logic sync_request_out,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic [15:0] sample_data
);
  logic [2:0] k_seen_reg;
  logic [2:0] beats_reg;
  wire logic beat = sample_valid && sample_ready;
  wire logic all_k = lane_k == 8'hff;
  // Both counts saturate at 7, well past the figures asserted on.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      k_seen_reg <= 3'h0;
      beats_reg <= 3'h0;
    end else begin
      if (all_k && k_seen_reg != 3'h7) begin
        k_seen_reg <= k_seen_reg + 3'h1;
      end
      if (beat && beats_reg != 3'h7) begin
        beats_reg <= beats_reg + 3'h1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_sync_release;
    all_k [*4] |-> ##[2:3] !sync_request_out;
  endproperty
  a_sync_release: assert property (p_sync_release) else $error("sync held");
  property p_sync_needs_k;
    $fell(sync_request_out) |-> k_seen_reg >= 3'h4;
  endproperty
  a_sync_needs_k: assert property (p_sync_needs_k) else $error("early release");
  property p_align_after_release;
    lane_ilas != 8'h00 |-> !sync_request_out;
  endproperty
  a_align_after_release: assert property (p_align_after_release) else $error("early");
  property p_k_all_lanes;
    lane_k != 8'h00 |-> all_k;
  endproperty
  a_k_all_lanes: assert property (p_k_all_lanes) else $error("partial K");
  property p_k_keeps_release;
    all_k && !sync_request_out |=> !sync_request_out;
  endproperty
  a_k_keeps_release: assert property (p_k_keeps_release) else $error("sync raised");
  property p_sample_hold;
    sample_valid && !sample_ready |=> sample_valid && $stable(sample_data);
  endproperty
  a_sample_hold: assert property (p_sample_hold) else $error("sample dropped");
  property p_full_after_fill;
    !sample_ready |-> beats_reg >= 3'h4;
  endproperty
  a_full_after_fill: assert property (p_full_after_fill) else $error("early full");
  property p_ready_falls_on_beat;
    $fell(sample_ready) |-> $past(beat);
  endproperty
  a_ready_falls_on_beat: assert property (p_ready_falls_on_beat) else $error("fell");
endmodule // stm_link_properties

// file: verification/serdes_rx_test_and_error_monitor_tb_top.sv
// Testbench joining transmitter and test monitor through the link.
`timescale 1ns/1ps
module serdes_rx_test_and_error_monitor_tb_top;
  import stm_pkg::*;
  logic clk;
  logic rst;
  logic reg_wr;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, inject_nit, inject_disp, inject_uek;
  stm_tx_mode_t mode;
  logic [1:0] poly_sel;
  logic [15:0] sample_base;
  logic [23:0] t1, t2;
  int n_mismatch, cmp_count, cyc_count;
  stm_link_if i_stm_link_if ();
  stm_rx_monitor i_stm_rx_monitor (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link(i_stm_link_if.dev));
  stm_tx_source i_stm_tx_source (.clk(clk), .rst(rst), .mode(mode), .poly_sel(poly_sel),
    .inject_nit(inject_nit), .inject_disp(inject_disp), .inject_uek(inject_uek),
    .sample_base(sample_base), .link(i_stm_link_if.tx));
  stm_link_properties i_stm_link_properties (.clk(clk), .rst(rst),
    .lane_k(i_stm_link_if.lane_k), .lane_ilas(i_stm_link_if.lane_ilas),
    .sync_request_out(i_stm_link_if.sync_request_out),
    .sample_valid(i_stm_link_if.sample_valid), .sample_ready(i_stm_link_if.sample_ready),
    .sample_data(i_stm_link_if.sample_data));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a);
    reg_addr <= a;
    @(posedge clk);
    @(negedge clk);
    v = reg_rdata;
    @(posedge clk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e, input string n);
    rd(a);
    chk(n, 24'(v), 24'(e));
  endtask
  task automatic ec(input int l, input int t, input logic [7:0] e);
    rc(A_ERR_COUNT0 + 12'(l * 4 + t), e, "err_count");
  endtask
  task automatic inj(input logic [7:0] n, input logic [7:0] d, input logic [7:0] u, input int k);
    inject_nit <= n;
    inject_disp <= d;
    inject_uek <= u;
    cyc(k);
    inject_nit <= 8'h00;
    inject_disp <= 8'h00;
    inject_uek <= 8'h00;
    cyc(4);
  endtask
  task automatic tally(input logic [1:0] s, input logic [2:0] l);
    wr(A_PAT_CTRL, {1'b0, l, s, 2'b00});
    rd(A_PAT_TALLY0);
    t1[7:0] = v;
    rd(A_PAT_TALLY1);
    t1[15:8] = v;
    rd(A_PAT_TALLY2);
    t1[23:16] = v;
  endtask
  // Clear pulse, run written 0 then 1, stop, then fetch the pass vector.
  task automatic prbs(input logic [1:0] s);
    wr(A_PAT_CTRL, {4'h0, s, 2'b01});
    wr(A_PAT_CTRL, {4'h0, s, 2'b00});
    wr(A_PAT_CTRL, {4'h0, s, 2'b10});
    cyc(80);
    wr(A_PAT_CTRL, {4'h0, s, 2'b00});
    rd(A_PAT_LANE_OK);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_count++;
    if (cyc_count == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    {rst, reg_wr, reg_addr, reg_wdata} = {1'b1, 1'b0, 12'h000, 8'h00};
    mode = STM_TX_IDLE;
    {poly_sel, sample_base} = {2'h0, 16'h1000};
    {inject_nit, inject_disp, inject_uek} = 24'h000000;
    {n_mismatch, cmp_count, cyc_count} = {32'd0, 32'd0, 32'd0};
    cyc(8);
    rst <= 1'b0;
    cyc(1);
    rc(A_PAT_CTRL, 8'h00, "pat_ctrl");
    for (int l = 0; l < LANES; l++) begin
      rc(A_ERR_CTRL0 + 12'(l), ERR_CTRL_RESET, "err_ctrl");
      wr(A_ERR_CTRL0 + 12'(l), 8'h38);
    end
    rc(12'h300, 8'h00, "unmapped");
    $display("done reset values");
    mode <= STM_TX_CGS;
    cyc(12);
    rc(A_CG_LOCKED, 8'hff, "cg_locked");
    chk("sync", 24'(i_stm_link_if.sync_request_out), 24'h0);
    inj(8'h00, 8'h01, 8'h00, 3);
    ec(0, ERR_BDE, 8'h03);
    inj(8'h04, 8'h04, 8'h00, 1);
    ec(2, ERR_NIT, 8'h01);
    ec(2, ERR_BDE, 8'h00);
    inj(8'h00, 8'h04, 8'h00, 1);
    ec(2, ERR_BDE, 8'h01);
    inj(8'h00, 8'h00, 8'h08, 2);
    ec(3, ERR_UEK, 8'h02);
    wr(A_ERR_CTRL0 + 12'h3, 8'h39);
    inj(8'h00, 8'h00, 8'h08, 2);
    ec(3, ERR_UEK, 8'h00);
    wr(A_ERR_CTRL0 + 12'h3, 8'h38);
    inj(8'h00, 8'h00, 8'h08, 1);
    ec(3, ERR_UEK, 8'h01);
    wr(A_READ_QUAL, 8'h10);
    inj(8'h02, 8'h00, 8'h00, 3);
    ec(1, ERR_BDE, 8'h01);
    ec(1, ERR_NIT, 8'h03);
    wr(A_READ_QUAL, 8'h00);
    wr(A_ERR_HOLD0 + 12'h4, 8'h04);
    inj(8'h00, 8'h30, 8'h00, 300);
    ec(4, ERR_BDE, ERR_TERMINAL);
    ec(5, ERR_BDE, 8'h2c);
    $display("done error counters");
    mode <= STM_TX_PRBS;
    wr(A_LANE_INVERT, 8'h06);
    wr(A_PAT_LANE_EN, 8'h03);
    wr(A_PAT_LIMIT0, 8'h10);
    for (int s = 0; s < 3; s++) begin
      poly_sel <= 2'(s);
      prbs(2'(s));
      chk("lane_ok", 24'(v & 8'h03), 24'h1);
      tally(2'(s), 3'h0);
      chk("tally0", t1, 24'h0);
      tally(2'(s), 3'h2);
      chk("tally2", t1, 24'h0);
      tally(2'(s), 3'h1);
      t2 = t1;
      chk("over_limit", 24'(t1 > 24'h10), 24'h1);
      cyc(20);
      tally(2'(s), 3'h1);
      chk("stopped", t1, t2);
    end
    wr(A_PAT_LIMIT0, 8'hff);
    rd(A_PAT_LANE_OK);
    chk("lane_ok_limit", 24'(v & 8'h03), 24'h3);
    wr(A_PAT_CTRL, 8'h19);
    tally(2'h2, 3'h1);
    chk("cleared", t1, 24'h0);
    $display("done pattern check");
    mode <= STM_TX_IDLE;
    poly_sel <= 2'h0;
    wr(A_LOOP_MASK, 8'h01);
    wr(A_LOOP_CTRL, 8'h01);
    wr(A_LOOP_CTRL, 8'h00);
    wr(A_PAT_LIMIT0, 8'h10);
    prbs(2'h0);
    chk("loopback_ok", 24'(v & 8'h03), 24'h1);
    wr(A_LOOP_MASK, 8'h00);
    $display("done loopback");
    mode <= STM_TX_SHORT_TRANSPORT_CHECK;
    wr(A_TPL_REF_LO, 8'hff);
    wr(A_TPL_REF_HI, 8'h0f);
    wr(A_TPL_CTRL, 8'h02);
    wr(A_TPL_CTRL, 8'h00);
    cyc(20);
    chk("sample_ready", 24'(i_stm_link_if.sample_ready), 24'h0);
    rd(A_TPL_RESULT);
    chk("idle_fail", 24'(v & 8'h01), 24'h0);
    wr(A_TPL_CTRL, 8'h01);
    cyc(300);
    rd(A_TPL_RESULT);
    chk("mismatch", 24'(v & 8'h01), 24'h1);
    wr(A_TPL_CTRL, 8'h02);
    wr(A_TPL_CTRL, 8'h00);
    rd(A_TPL_RESULT);
    chk("fail_cleared", 24'(v & 8'h01), 24'h0);
    // Only converter 1, Q, sample 5 is compared; every other slot differs from the reference.
    wr(A_TPL_REF_LO, 8'h35);
    wr(A_TPL_REF_HI, 8'h10);
    wr(A_TPL_RESULT, 8'h40);
    wr(A_TPL_CTRL, 8'h56);
    wr(A_TPL_CTRL, 8'h55);
    cyc(300);
    rd(A_TPL_RESULT);
    chk("selected_match", 24'(v), 24'h40);
    $display("done sample check");
    rst <= 1'b1;
    mode <= STM_TX_IDLE;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    wr(A_ILAS_MODE, 8'h80);
    mode <= STM_TX_ILAS;
    cyc(60);
    rc(A_ILAS_MODE, 8'h80, "ilas_mode");
    rc(A_LANE_ALIGNED, 8'hff, "aligned");
    chk("sync_ilas", 24'(i_stm_link_if.sync_request_out), 24'h0);
    $display("done alignment repeat");
    final_report();
  end
endmodule // serdes_rx_test_and_error_monitor_tb_top
